//--- rtl/dhip_port.sv
`timescale 1ns/1ps
// ============================================================
// display host interface port, device end
// ============================================================
// Summary of operation
// - data select high: byte is display data
// - data select low: byte goes to command
// - enable mode: cycle needs enable high, select low
// - split mode: write strobe low starts write
// - split mode: read strobe low drives bus
// - chip select high: all activity ignored
// - reset pin low reinitialises all state
// - pick pins choose protocol mode
// - bus driven by device only when reading
// - serial: data line 1, clock line 0
module dhip_port (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       host_reset_n_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       data_command_select_i,
  input  wire logic       host_put_strobe_i,
  input  wire logic       read_strobe_i,
  input  wire logic       iface_pick_lo_i,
  input  wire logic       iface_pick_hi_i,
  input  wire logic [7:0] host_byte_lines_i,
  output logic      [7:0] host_byte_lines_o,
  output logic            host_byte_lines_oe_o,
  input  wire logic [7:0] read_byte_i,
  output logic            disp_valid_o,
  input  wire logic       disp_ready_i,
  output logic      [7:0] disp_data_o,
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_byte_o,
  output logic            host_busy_o,
  output logic            data_overrun_o
);

  // ============================================================
  // internal signals
  // ============================================================
  logic                  rst;          // board reset or host reset pin
  dhip_pkg::dhip_mode_type mode;       // protocol in force
  logic                  wr_act;       // parallel write condition holds
  logic                  rd_act;       // parallel read condition holds
  logic                  wr_act_prev;  // write condition one cycle ago
  logic                  rd_act_prev;  // read condition one cycle ago
  logic                  sclk_prev;    // serial clock one cycle ago
  logic                  sclk_rise;    // qualified serial clock edge
  logic [2:0]            bit_cnt;      // serial bits taken so far
  logic [6:0]            shift;        // serial bits gathered, msb first
  logic                  wr_fire;      // one byte accepted this cycle
  logic                  wr_dc;        // its data or command steering
  logic [7:0]            wr_byte;      // the byte itself
  logic                  fifo_in_valid;  // display byte offered to buffer
  logic [7:0]            fifo_in_data;   // display byte held for buffer
  logic                  fifo_in_ready;  // buffer has room

  // the reset pin acts like the board reset, inputs are synchronous
  assign rst = reset_i || !host_reset_n_i;

  // ============================================================
  // protocol selection
  // ============================================================
  // sampled every cycle; changing the pins mid-transfer is not supported
  always_ff @(posedge clock_i) begin
    if (rst) begin
      mode <= dhip_pkg::MODE_RESET;
    end else begin
      mode <= dhip_pkg::dhip_mode_type'({iface_pick_hi_i, iface_pick_lo_i});
    end
  end

  // ============================================================
  // parallel cycle conditions
  // ============================================================
  always_comb begin
    wr_act = 1'b0;
    rd_act = 1'b0;
    case (mode)
      dhip_pkg::MODE_ENABLE: begin
        // direction line high reads, low writes; enable high opens the cycle
        wr_act = !chip_select_n_i && read_strobe_i && !host_put_strobe_i;
        rd_act = !chip_select_n_i && read_strobe_i && host_put_strobe_i;
      end
      dhip_pkg::MODE_SPLIT: begin
        wr_act = !chip_select_n_i && !host_put_strobe_i;
        rd_act = !chip_select_n_i && !read_strobe_i;
      end
      default: begin
        // serial and two-wire modes never use the strobes
        wr_act = 1'b0;
        rd_act = 1'b0;
      end
    endcase
  end

  // ============================================================
  // strobe and serial clock history
  // ============================================================
  always_ff @(posedge clock_i) begin
    if (rst) begin
      wr_act_prev <= 1'b0;
      rd_act_prev <= 1'b0;
      sclk_prev   <= 1'b0;
    end else begin
      wr_act_prev <= wr_act;
      rd_act_prev <= rd_act;
      sclk_prev   <= host_byte_lines_i[dhip_pkg::SCLK_LINE];
    end
  end

  // a serial edge only counts while the chip is selected
  assign sclk_rise = (mode == dhip_pkg::MODE_SERIAL) && !chip_select_n_i
                     && host_byte_lines_i[dhip_pkg::SCLK_LINE] && !sclk_prev;

  // ============================================================
  // serial shifter
  // ============================================================
  // deselect restarts the byte so a stray clock cannot misalign the next one
  always_ff @(posedge clock_i) begin
    if (rst || chip_select_n_i) begin
      bit_cnt <= dhip_pkg::BIT_FIRST;
      shift   <= '0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'h1;  // wraps to zero after the last bit
      shift   <= {shift[5:0], host_byte_lines_i[dhip_pkg::SERIAL_IN_LINE_LINE]};
    end
  end

  // ============================================================
  // byte acceptance, one cycle per transfer
  // ============================================================
  always_comb begin
    wr_fire = 1'b0;
    wr_dc   = data_command_select_i;  // steering sampled with the byte
    wr_byte = host_byte_lines_i;
    if (mode == dhip_pkg::MODE_SERIAL) begin
      // steering is taken alongside the eighth bit
      wr_fire = sclk_rise && (bit_cnt == dhip_pkg::BIT_LAST);
      wr_byte = {shift, host_byte_lines_i[dhip_pkg::SERIAL_IN_LINE_LINE]};
    end else begin
      // parallel byte is taken in the first cycle of the write strobe
      wr_fire = wr_act && !wr_act_prev;
    end
  end

  // ============================================================
  // steering to display data or command
  // ============================================================
  always_ff @(posedge clock_i) begin
    if (rst) begin
      fifo_in_valid  <= 1'b0;
      fifo_in_data   <= dhip_pkg::BYTE_RESET;
      cmd_valid_o    <= 1'b0;
      cmd_byte_o     <= dhip_pkg::BYTE_RESET;
      data_overrun_o <= 1'b0;
    end else begin
      // a byte refused by a full buffer is lost and flagged for one cycle
      data_overrun_o <= fifo_in_valid && !fifo_in_ready;
      fifo_in_valid  <= wr_fire && wr_dc;
      cmd_valid_o    <= wr_fire && !wr_dc;
      if (wr_fire && wr_dc) begin
        fifo_in_data <= wr_byte;
      end
      if (wr_fire && !wr_dc) begin
        cmd_byte_o <= wr_byte;
      end
    end
  end

  // ============================================================
  // read return, bus driven only inside a read cycle
  // ============================================================
  always_ff @(posedge clock_i) begin
    if (rst) begin
      host_byte_lines_oe_o <= 1'b0;
      host_byte_lines_o    <= dhip_pkg::BYTE_RESET;
    end else begin
      host_byte_lines_oe_o <= rd_act;
      if (rd_act && !rd_act_prev) begin
        host_byte_lines_o <= read_byte_i;  // held for the whole read
      end
    end
  end

  // ============================================================
  // back-pressure seen by the host, one cycle late
  // ============================================================
  always_ff @(posedge clock_i) begin
    if (rst) begin
      host_busy_o <= 1'b0;
    end else begin
      host_busy_o <= !fifo_in_ready;
    end
  end

  // ============================================================
  // display data buffer
  // ============================================================
  dhip_fifo #(
    .WIDTH (dhip_pkg::DATA_WIDTH),
    .DEPTH (dhip_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_i     (rst),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (disp_valid_o),
    .out_ready_i (disp_ready_i),
    .out_data_o  (disp_data_o)
  );

  // ============================================================
  // checks
  // ============================================================
  AST_DATA_PATH: assert property (@(posedge clock_i) disable iff (rst)
    wr_fire && wr_dc |=> fifo_in_valid && fifo_in_data == $past(wr_byte))
    else $error("display byte not offered to buffer");

  AST_CMD_PATH: assert property (@(posedge clock_i) disable iff (rst)
    wr_fire && !wr_dc |=> cmd_valid_o && !fifo_in_valid && cmd_byte_o == $past(wr_byte))
    else $error("command byte not delivered");

  AST_ENABLE_START: assert property (@(posedge clock_i) disable iff (rst)
    (cmd_valid_o || fifo_in_valid) && $past(mode) == dhip_pkg::MODE_ENABLE
    |-> $past(read_strobe_i && !chip_select_n_i && !host_put_strobe_i))
    else $error("enable mode write outside enable window");

  AST_SPLIT_WRITE: assert property (@(posedge clock_i) disable iff (rst)
    mode == dhip_pkg::MODE_SPLIT && !chip_select_n_i && $fell(host_put_strobe_i)
    |-> wr_fire)
    else $error("split mode write strobe missed");

  AST_SPLIT_READ: assert property (@(posedge clock_i) disable iff (rst)
    mode == dhip_pkg::MODE_SPLIT && rd_act && !rd_act_prev
    |=> host_byte_lines_oe_o && host_byte_lines_o == $past(read_byte_i))
    else $error("split mode read not driven");

  AST_SELECT_GATE: assert property (@(posedge clock_i) disable iff (rst)
    chip_select_n_i |-> !wr_fire ##1 !host_byte_lines_oe_o && !cmd_valid_o && !fifo_in_valid)
    else $error("activity while deselected");

  AST_PIN_RESET: assert property (@(posedge clock_i) disable iff (reset_i)
    !host_reset_n_i |=> !cmd_valid_o && !host_byte_lines_oe_o && !disp_valid_o
                        && mode == dhip_pkg::MODE_RESET)
    else $error("reset pin did not reinitialise");

  AST_MODE_PICK: assert property (@(posedge clock_i) disable iff (rst)
    iface_pick_hi_i && !iface_pick_lo_i ##1 !rst |-> mode == dhip_pkg::MODE_ENABLE)
    else $error("protocol pick not applied");

  AST_DRIVE_READ_ONLY: assert property (@(posedge clock_i) disable iff (rst)
    host_byte_lines_oe_o |-> $past(rd_act) && mode != dhip_pkg::MODE_SERIAL)
    else $error("bus driven outside read");

  AST_SERIAL_BYTE: assert property (@(posedge clock_i) disable iff (rst)
    sclk_rise && bit_cnt == dhip_pkg::BIT_LAST
    |=> bit_cnt == dhip_pkg::BIT_FIRST && (cmd_valid_o || fifo_in_valid)
        && (cmd_valid_o ? cmd_byte_o : fifo_in_data)
           == $past({shift, host_byte_lines_i[dhip_pkg::SERIAL_IN_LINE_LINE]}))
    else $error("serial byte not closed on eighth bit");

endmodule : dhip_port

//--- pkg/dhip_pkg.sv
// ============================================================
// shared constants of the display host interface port
// ============================================================
package dhip_pkg;

  // ============================================================
  // widths and depths
  // ============================================================
  localparam int DATA_WIDTH = 8;   // host bus is one byte wide
  localparam int FIFO_DEPTH = 16;  // display data buffer entries

  // ============================================================
  // serial mode line positions on the host bus
  // ============================================================
  localparam int SCLK_LINE = 0;    // serial clock arrives on bus line 0
  localparam int SERIAL_IN_LINE_LINE = 1;    // serial data arrives on bus line 1

  // ============================================================
  // serial bit counter
  // ============================================================
  localparam logic [2:0] BIT_FIRST = 3'h0;  // count after reset or deselect
  localparam logic [2:0] BIT_LAST  = 3'h7;  // eighth bit closes a byte

  // ============================================================
  // reset values
  // ============================================================
  localparam logic [7:0] BYTE_RESET = 8'h00;  // cleared data registers

  // ============================================================
  // host protocol, coded as {iface_pick_hi, iface_pick_lo}
  // ============================================================
  typedef enum logic [1:0] {
    MODE_SERIAL  = 2'b00,  // lo 0, hi 0
    MODE_TWOWIRE = 2'b01,  // lo 1, hi 0
    MODE_ENABLE  = 2'b10,  // lo 0, hi 1
    MODE_SPLIT   = 2'b11   // lo 1, hi 1
  } dhip_mode_type;

  localparam dhip_mode_type MODE_RESET = MODE_SERIAL;  // mode after reset

endpackage : dhip_pkg

//--- rtl/dhip_fifo.sv
`timescale 1ns/1ps
// ============================================================
// small synchronous fifo with a registered output stage
// ============================================================
module dhip_fifo #(
  parameter int WIDTH = 8,   // word width
  parameter int DEPTH = 16   // storage words, a power of two
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);      // pointer width
  localparam int CW = $clog2(DEPTH + 1);  // occupancy width

  logic [WIDTH-1:0] mem [DEPTH];  // storage array
  logic [PW-1:0]    wr_ptr;       // next slot written
  logic [PW-1:0]    rd_ptr;       // next slot read
  logic [CW-1:0]    count;        // words held in the array
  logic             push;         // word accepted this cycle
  logic             pop;          // word moved to the output stage

  // full is honest: the array refuses a word once every slot holds one
  assign in_ready_o = (count != CW'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  // output stage reloads when empty or being drained
  assign pop        = (count != '0) && (!out_valid_o || out_ready_i);

  // ============================================================
  // storage write, no reset needed on the array
  // ============================================================
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // ============================================================
  // pointers and occupancy
  // ============================================================
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  // ============================================================
  // registered output stage
  // ============================================================
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;  // word taken, nothing behind it
    end
  end

endmodule : dhip_fifo

//--- dv/dhip_host_model.sv
`timescale 1ns/1ps
// ============================================================
// host model: drives select, strobes and bus like a small cpu
// ============================================================
module dhip_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] bus_i,
  output logic            cs_n_o,
  output logic            dc_o,
  output logic            put_o,
  output logic            rd_o,
  output logic      [7:0] bus_o
);
  logic split;  // high while split strobes are in use

  // ============================================================
  // everything idle at time zero
  // ============================================================
  initial begin
    split  = 1'b0;
    cs_n_o = 1'b1;
    dc_o   = 1'b0;
    put_o  = 1'b0;
    rd_o   = 1'b0;
    bus_o  = 8'h00;
  end

  // strobes to rest level; a released bus never keeps its last value
  task automatic idle(input logic s);
    @(posedge clock_i);
    #2;
    split  = s;
    cs_n_o = 1'b1;
    put_o  = s;
    rd_o   = s;
    bus_o  = ~bus_o;
  endtask : idle

  // one parallel write, strobe held two cycles then released
  task automatic put_byte(input logic cs_n, input logic dc, input logic [7:0] b);
    @(posedge clock_i);
    #2;
    cs_n_o = cs_n;
    dc_o   = dc;
    bus_o  = b;
    put_o  = 1'b0;
    rd_o   = 1'b1;    // enable high, or split read strobe kept idle
    repeat (2) @(posedge clock_i);
    #2;
    put_o  = split;
    rd_o   = split;
    cs_n_o = 1'b1;
    bus_o  = ~b;
  endtask : put_byte

  // one parallel read, bus released, sampled after three edges
  task automatic get_byte(output logic [7:0] b);
    @(posedge clock_i);
    #2;
    cs_n_o = 1'b0;
    put_o  = 1'b1;
    rd_o   = ~split;
    bus_o  = ~bus_o;
    repeat (3) @(posedge clock_i);
    b = bus_i;
    #2;
    put_o  = split;
    rd_o   = split;
    cs_n_o = 1'b1;
  endtask : get_byte

  // one serial byte; the serial clock rests low outside the frame
  task automatic shift_byte(input logic dc, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock_i);
      #2;
      cs_n_o   = 1'b0;
      dc_o     = dc;
      bus_o[0] = 1'b0;
      bus_o[1] = b[i];
      @(posedge clock_i);
      #2;
      bus_o[0] = 1'b1;
    end
    @(posedge clock_i);
    #2;
    bus_o[0] = 1'b0;
    cs_n_o   = 1'b1;
  endtask : shift_byte
endmodule : dhip_host_model

//--- dv/test_dhip_port.sv
`timescale 1ns/1ps
// ============================================================
// testbench of the host interface port
// ============================================================
module test_dhip_port;
  logic       clock, reset, host_reset_n, pick_lo, pick_hi, disp_ready;
  logic       cs_n, dc, put, rd, oe, disp_valid, cmd_valid, busy, overrun;
  logic [7:0] host_bus, dev_bus, bus, read_byte, disp_data, cmd_byte, v;
  int         num_errors, total_checks, cycles, cmd_count, ovr_count, n;
  logic [7:0] got_q[$];  // display bytes taken by the consumer

  assign bus = oe ? dev_bus : host_bus;  // device wins only while it drives

  dhip_host_model dhip_host_model_i (.clock_i(clock), .bus_i(bus), .cs_n_o(cs_n),
    .dc_o(dc), .put_o(put), .rd_o(rd), .bus_o(host_bus));
  dhip_port dhip_port_i (.clock_i(clock), .reset_i(reset), .host_reset_n_i(host_reset_n),
    .chip_select_n_i(cs_n), .data_command_select_i(dc), .host_put_strobe_i(put),
    .read_strobe_i(rd), .iface_pick_lo_i(pick_lo), .iface_pick_hi_i(pick_hi),
    .host_byte_lines_i(bus), .host_byte_lines_o(dev_bus), .host_byte_lines_oe_o(oe),
    .read_byte_i(read_byte), .disp_valid_o(disp_valid), .disp_ready_i(disp_ready),
    .disp_data_o(disp_data), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
    .host_busy_o(busy), .data_overrun_o(overrun));

  // ============================================================
  // clock, monitors and hang limit
  // ============================================================
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cmd_valid === 1'b1) cmd_count++;
    if (overrun === 1'b1) ovr_count++;
    if (disp_valid === 1'b1 && disp_ready === 1'b1) got_q.push_back(disp_data);
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // new pick pins need a registered edge before the first request
  task automatic set_mode(input logic hi, input logic lo);
    @(posedge clock);
    #2;
    pick_hi = hi;
    pick_lo = lo;
    dhip_host_model_i.idle(hi & lo);
    repeat (2) @(posedge clock);
    #2;
    got_q.delete();
  endtask : set_mode

  // ============================================================
  // scenarios
  // ============================================================
  task automatic t_parallel(input logic hi, input logic lo, input logic [7:0] b);
    set_mode(hi, lo);
    n = cmd_count;
    dhip_host_model_i.put_byte(1'b0, 1'b0, b);
    dhip_host_model_i.put_byte(1'b1, 1'b0, ~b);
    dhip_host_model_i.put_byte(1'b0, 1'b1, b ^ 8'h0f);
    repeat (4) @(posedge clock);
    check("cmd count", 8'(n + 1), 8'(cmd_count));
    check("cmd byte", b, cmd_byte);
    check("data count", 8'h01, 8'(got_q.size()));
    if (got_q.size() > 0) check("data byte", b ^ 8'h0f, got_q[0]);
    read_byte = ~b;
    dhip_host_model_i.get_byte(v);
    check("read byte", ~b, v);
    repeat (2) @(posedge clock);
    check("bus released", 8'h00, {7'h00, oe});
  endtask : t_parallel

  task automatic t_serial();
    set_mode(1'b0, 1'b0);
    n = cmd_count;
    dhip_host_model_i.shift_byte(1'b0, 8'hb4);
    dhip_host_model_i.shift_byte(1'b1, 8'h2d);
    repeat (6) @(posedge clock);
    check("serial cmd", 8'hb4, cmd_byte);
    check("serial count", 8'(n + 1), 8'(cmd_count));
    if (got_q.size() > 0) check("serial data", 8'h2d, got_q[0]);
    else check("serial data count", 8'h01, 8'h00);
    set_mode(1'b0, 1'b1);
    dhip_host_model_i.shift_byte(1'b0, 8'h11);
    dhip_host_model_i.get_byte(v);
    check("two-wire ignored", 8'(n + 1), 8'(cmd_count));
    check("two-wire oe", 8'h00, {7'h00, oe});
  endtask : t_serial

  // fill 17 words with the consumer stalled, overflow once, drain in order
  task automatic t_fifo();
    set_mode(1'b1, 1'b0);
    disp_ready = 1'b0;
    n = ovr_count;
    for (int i = 0; i < 18; i++) dhip_host_model_i.put_byte(1'b0, 1'b1, 8'(i));
    repeat (3) @(posedge clock);
    check("busy", 8'h01, {7'h00, busy});
    check("overrun", 8'(n + 1), 8'(ovr_count));
    #2;
    disp_ready = 1'b1;
    repeat (30) @(posedge clock);
    check("drained", 8'd17, 8'(got_q.size()));
    for (int i = 0; i < 17 && i < got_q.size(); i++) check("order", 8'(i), got_q[i]);
  endtask : t_fifo

  task automatic t_reset();
    set_mode(1'b1, 1'b1);
    disp_ready = 1'b0;
    dhip_host_model_i.put_byte(1'b0, 1'b0, 8'h77);
    dhip_host_model_i.put_byte(1'b0, 1'b1, 8'h66);
    repeat (3) @(posedge clock);
    #2;
    host_reset_n = 1'b0;
    repeat (2) @(posedge clock);
    #2;
    check("cmd after reset", 8'h00, cmd_byte);
    check("valid after reset", 8'h00, {7'h00, disp_valid});
    host_reset_n = 1'b1;
    disp_ready = 1'b1;
  endtask : t_reset

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // ============================================================
  // main sequence
  // ============================================================
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    host_reset_n = 1'b1;
    pick_lo = 1'b0;
    pick_hi = 1'b1;
    disp_ready = 1'b1;
    read_byte = 8'h00;
    repeat (8) @(posedge clock);
    #2;
    reset = 1'b0;
    t_parallel(1'b1, 1'b0, 8'h3c);
    t_parallel(1'b1, 1'b1, 8'h81);
    t_serial();
    t_fifo();
    t_reset();
    t_parallel(1'b1, 1'b0, 8'hc5);
    end_of_test();
  end
endmodule : test_dhip_port
